// *** design/mcel_cfg.svh ***
`ifndef MCEL_CFG_SVH
`define MCEL_CFG_SVH

// register byte offsets on the bus
`define MCEL_OFS_FIRST_FAT    8'h98
`define MCEL_OFS_NEXT_FAT     8'h9c
`define MCEL_OFS_FIRST_NF     8'ha0
`define MCEL_OFS_NEXT_NF      8'ha4
`define MCEL_OFS_MASK         8'ha8

// flag field widths and channel index field position
`define MCEL_FAT_W            3
`define MCEL_NF_W             25
`define MCEL_IDX_LSB          28
`define MCEL_IDX_W            2

// fatal flag positions
`define MCEL_FAT_THERMAL_BIT  2

// position of each class inside the mask register
`define MCEL_FAT_MASK_LSB     0
`define MCEL_NF_MASK_LSB      3

// mask reset value and writable bits (bit 15 and 31:28 reserved)
`define MCEL_MASK_RST         32'h0fff7fff
`define MCEL_MASK_WR          32'h0fff7fff

// non-fatal bits that hardware may set (12 and 22:19 never)
`define MCEL_NF_HW_MASK       25'h187efff

`endif

// *** design/mcel_log.sv ***
`timescale 1ns/1ps
`default_nettype none

// first/next error log pair of one severity class
module mcel_log #(
    parameter int W  = 3,
    parameter int IW = 2
) (
    input  wire logic          mclk,
    input  wire logic          rst_por,
    input  wire logic          ce,
    input  wire logic          any,
    input  wire logic [W-1:0]  win_flag,
    input  wire logic [IW-1:0] win_idx,
    input  wire logic [W-1:0]  rest,
    input  wire logic [W-1:0]  all_or,
    input  wire logic [W-1:0]  clr_first,
    input  wire logic [W-1:0]  clr_next,
    output logic [W-1:0]       first,
    output logic [IW-1:0]      idx,
    output logic [W-1:0]       next
);

    typedef struct packed {
        logic [W-1:0]  first;  // single captured flag
        logic [IW-1:0] idx;    // channel of the captured flag
        logic [W-1:0]  next;   // accumulated later errors
    } mcel_log_st_t;

    mcel_log_st_t cur;
    mcel_log_st_t next_st;
    logic [W-1:0] kept;

    // write-one-clear with set winning; capture only into an empty first log
    always_comb begin
        next_st = cur;
        kept    = cur.first & ~clr_first;
        if ((kept == '0) && any) begin
            next_st.first = win_flag;
            next_st.idx   = win_idx;
            next_st.next  = (cur.next & ~clr_next) | rest;
        end else begin
            next_st.first = kept;
            next_st.next  = (cur.next & ~clr_next) | all_or;
        end
    end

    // sticky storage, cleared only by power-on reset or a write-one-clear
    always_ff @(posedge mclk) begin
        if (rst_por) begin
            cur <= '0;
        end else if (ce) begin
            cur <= next_st;
        end
    end

    assign first = cur.first;
    assign idx   = cur.idx;
    assign next  = cur.next;

    property p_first_onehot;
        @(posedge mclk) disable iff (rst_por) $onehot0(cur.first);
    endproperty
    a_first_onehot: assert property (p_first_onehot)
        else $error("first log holds more than one flag");

    property p_first_hold;
        @(posedge mclk) disable iff (rst_por)
            (ce && (cur.first != '0) && (clr_first == '0)) |=> (cur.first == $past(cur.first));
    endproperty
    a_first_hold: assert property (p_first_hold)
        else $error("occupied first log was overwritten");

    property p_next_logs;
        @(posedge mclk) disable iff (rst_por)
            (ce && ((cur.first & ~clr_first) != '0) && (all_or != '0))
            |=> ((cur.next & $past(all_or)) == $past(all_or));
    endproperty
    a_next_logs: assert property (p_next_logs)
        else $error("later error missing from next log");

    property p_next_clear;
        @(posedge mclk) disable iff (rst_por)
            (ce && (all_or == '0)) |=> ((cur.next & $past(clr_next)) == '0);
    endproperty
    a_next_clear: assert property (p_next_clear)
        else $error("write one did not clear next log");

endmodule : mcel_log

`default_nettype wire

// *** design/mcel_pick.sv ***
`timescale 1ns/1ps
`default_nettype none

// picks the winning error among all channels: lowest channel, then highest bit
module mcel_pick #(
    parameter int NCH = 4,
    parameter int W   = 3,
    parameter int IW  = 2
) (
    input  wire logic [NCH*W-1:0] evt,
    output logic                  any,
    output logic [W-1:0]          win_flag,
    output logic [IW-1:0]         win_idx,
    output logic [W-1:0]          rest,
    output logic [W-1:0]          all_or
);

    // one-hot of the highest set bit
    function automatic logic [W-1:0] hi_bit(input logic [W-1:0] v);
        logic [W-1:0] r;
        r = '0;
        for (int b = 0; b < W; b++) begin
            if (v[b]) begin
                r = '0;
                r[b] = 1'b1;
            end
        end
        return r;
    endfunction : hi_bit

    // scan channels in ascending order, first busy channel wins
    always_comb begin
        any      = 1'b0;
        win_flag = '0;
        win_idx  = '0;
        rest     = '0;
        all_or   = '0;
        for (int c = 0; c < NCH; c++) begin
            all_or = all_or | evt[c*W +: W];
            if (!any && (|evt[c*W +: W])) begin
                any      = 1'b1;
                win_flag = hi_bit(evt[c*W +: W]);
                win_idx  = IW'(c);
            end
        end
        // everything except the winner itself goes to the next-error log
        for (int c = 0; c < NCH; c++) begin
            if (any && (win_idx == IW'(c))) begin
                rest = rest | (evt[c*W +: W] & ~win_flag);
            end else begin
                rest = rest | evt[c*W +: W];
            end
        end
    end

endmodule : mcel_pick

`default_nettype wire

// *** design/mcel_pkg.sv ***
package mcel_pkg;

    // bus slave states, one-hot
    typedef enum logic [1:0] {
        MCEL_IDLE = 2'h1,
        MCEL_ACK  = 2'h2
    } mcel_bus_state_t;

    // complete state of the top module
    typedef struct packed {
        mcel_bus_state_t state;    // bus slave state
        logic            waitreq;  // avalon waitrequest
        logic [31:0]     rdata;    // avalon readdata
        logic [31:0]     mask;     // error mask, sticky
    } mcel_top_st_t;

endpackage : mcel_pkg

// *** design/mcel_top.sv ***
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

`include "mcel_cfg.svh"

module mcel_top
    import mcel_pkg::*;
#(
    parameter int NUM_BRANCH      = 2,  // memory branches
    parameter int CHAN_PER_BRANCH = 2   // channels in each branch
) (
    input  wire logic                     mclk,
    input  wire logic                     rst,
    input  wire logic                     rst_por,
    input  wire logic                     ce,
    input  wire logic [NUM_BRANCH*CHAN_PER_BRANCH*`MCEL_FAT_W-1:0] fatal_evt,
    input  wire logic [NUM_BRANCH*CHAN_PER_BRANCH*`MCEL_NF_W-1:0]  nonfatal_evt,
    input  wire logic [7:0]               avs_address,
    input  wire logic                     avs_read,
    input  wire logic                     avs_write,
    input  wire logic [31:0]              avs_writedata,
    input  wire logic [3:0]               avs_byteenable,
    output logic [31:0]                   avs_readdata,
    output logic                          avs_waitrequest
);

    localparam int NCH = NUM_BRANCH * CHAN_PER_BRANCH;  // total channels
    localparam int FW  = `MCEL_FAT_W;                   // fatal flag width
    localparam int NW  = `MCEL_NF_W;                    // non-fatal flag width
    localparam int IW  = `MCEL_IDX_W;                   // channel index width

    // the index field cannot name more than four channels; refused at elaboration
    if ((NUM_BRANCH < 1) || (CHAN_PER_BRANCH < 1) || (NCH > (1 << IW))) begin : g_bad_cfg
        $error("unsupported branch or channel count");
    end

    mcel_top_st_t cur;       // registered state
    mcel_top_st_t next_st;   // next state

    // events after masking, per channel
    logic [NCH*FW-1:0] fat_gated;
    logic [NCH*NW-1:0] nf_gated;

    // priority pick results, fatal class
    logic              fat_any;
    logic [FW-1:0]     fat_win;
    logic [IW-1:0]     fat_widx;
    logic [FW-1:0]     fat_rest;
    logic [FW-1:0]     fat_all;

    // priority pick results, non-fatal class
    logic              nf_any;
    logic [NW-1:0]     nf_win;
    logic [IW-1:0]     nf_widx;
    logic [NW-1:0]     nf_rest;
    logic [NW-1:0]     nf_all;

    // log contents
    logic [FW-1:0]     fat_first;
    logic [IW-1:0]     fat_idx;
    logic [FW-1:0]     fat_next;
    logic [NW-1:0]     nf_first;
    logic [IW-1:0]     nf_idx;
    logic [NW-1:0]     nf_next;

    // write-one-clear strobes toward the logs
    logic [FW-1:0]     fat_clr_first;
    logic [FW-1:0]     fat_clr_next;
    logic [NW-1:0]     nf_clr_first;
    logic [NW-1:0]     nf_clr_next;

    // bus helpers
    logic [4:0]        sel;
    logic [31:0]       be_bits;
    logic [31:0]       wr_ones;

    // channel c is branch (c / CHAN_PER_BRANCH), so ascending c is branch-major order
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_gate
            // fatal: mask bit one blocks the source
            assign fat_gated[g*FW +: FW] = fatal_evt[g*FW +: FW]
                & ~cur.mask[`MCEL_FAT_MASK_LSB +: FW];
            // non-fatal: also drop bits hardware never sets
            assign nf_gated[g*NW +: NW] = nonfatal_evt[g*NW +: NW]
                & ~cur.mask[`MCEL_NF_MASK_LSB +: NW]
                & `MCEL_NF_HW_MASK;
        end
    endgenerate

    // fatal class priority: lowest channel first, then highest bit
    mcel_pick #(
        .NCH (NCH),
        .W   (FW),
        .IW  (IW)
    ) u_pick_fat (
        .evt      (fat_gated),
        .any      (fat_any),
        .win_flag (fat_win),
        .win_idx  (fat_widx),
        .rest     (fat_rest),
        .all_or   (fat_all)
    );

    // non-fatal class priority, same ordering
    mcel_pick #(
        .NCH (NCH),
        .W   (NW),
        .IW  (IW)
    ) u_pick_nf (
        .evt      (nf_gated),
        .any      (nf_any),
        .win_flag (nf_win),
        .win_idx  (nf_widx),
        .rest     (nf_rest),
        .all_or   (nf_all)
    );

    // fatal first/next logs
    mcel_log #(
        .W  (FW),
        .IW (IW)
    ) u_log_fat (
        .mclk      (mclk),
        .rst_por   (rst_por),
        .ce        (ce),
        .any       (fat_any),
        .win_flag  (fat_win),
        .win_idx   (fat_widx),
        .rest      (fat_rest),
        .all_or    (fat_all),
        .clr_first (fat_clr_first),
        .clr_next  (fat_clr_next),
        .first     (fat_first),
        .idx       (fat_idx),
        .next      (fat_next)
    );

    // non-fatal first/next logs; channel number kept for the first flag only
    mcel_log #(
        .W  (NW),
        .IW (IW)
    ) u_log_nf (
        .mclk      (mclk),
        .rst_por   (rst_por),
        .ce        (ce),
        .any       (nf_any),
        .win_flag  (nf_win),
        .win_idx   (nf_widx),
        .rest      (nf_rest),
        .all_or    (nf_all),
        .clr_first (nf_clr_first),
        .clr_next  (nf_clr_next),
        .first     (nf_first),
        .idx       (nf_idx),
        .next      (nf_next)
    );

    // address decode, one-hot over the five registers
    function automatic logic [4:0] reg_sel(input logic [7:0] a);
        logic [4:0] s;
        s = 5'h00;
        case (a)
            `MCEL_OFS_FIRST_FAT: s = 5'h01;
            `MCEL_OFS_NEXT_FAT:  s = 5'h02;
            `MCEL_OFS_FIRST_NF:  s = 5'h04;
            `MCEL_OFS_NEXT_NF:   s = 5'h08;
            `MCEL_OFS_MASK:      s = 5'h10;
            default:             s = 5'h00;
        endcase
        return s;
    endfunction : reg_sel

    // read word for a decoded register; unmapped reads as zero
    function automatic logic [31:0] read_word(input logic [4:0] s);
        logic [31:0] r;
        r = 32'h0;
        if (s[0]) begin
            r[FW-1:0] = fat_first;
            r[`MCEL_IDX_LSB +: IW] = fat_idx;
        end
        if (s[1]) begin
            r[FW-1:0] = fat_next;
        end
        if (s[2]) begin
            r[NW-1:0] = nf_first;
            r[`MCEL_IDX_LSB +: IW] = nf_idx;
        end
        if (s[3]) begin
            r[NW-1:0] = nf_next;
        end
        if (s[4]) begin
            r = cur.mask;
        end
        return r;
    endfunction : read_word

    assign sel     = reg_sel(avs_address);
    assign be_bits = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wr_ones = avs_writedata & be_bits;

    // bus slave: request seen in idle, waitrequest low for one cycle, write acts then
    always_comb begin
        next_st       = cur;
        fat_clr_first = '0;
        fat_clr_next  = '0;
        nf_clr_first  = '0;
        nf_clr_next   = '0;
        case (cur.state)
            MCEL_IDLE: begin
                // accept a request and prepare the answer
                if (avs_read || avs_write) begin
                    next_st.state   = MCEL_ACK;
                    next_st.waitreq = 1'b0;
                    next_st.rdata   = avs_read ? read_word(sel) : 32'h0;
                end
            end
            MCEL_ACK: begin
                // the master samples waitrequest low at this edge
                next_st.state   = MCEL_IDLE;
                next_st.waitreq = 1'b1;
                if (avs_write) begin
                    // write one clears a flag, zero leaves it
                    if (sel[0]) begin
                        fat_clr_first = wr_ones[FW-1:0];
                    end
                    if (sel[1]) begin
                        fat_clr_next = wr_ones[FW-1:0];
                    end
                    if (sel[2]) begin
                        nf_clr_first = wr_ones[NW-1:0];
                    end
                    if (sel[3]) begin
                        nf_clr_next = wr_ones[NW-1:0];
                    end
                    // mask is plain read/write on its defined bits
                    if (sel[4]) begin
                        next_st.mask = ((cur.mask & ~be_bits) | wr_ones)
                            & `MCEL_MASK_WR;
                    end
                end
            end
            default: begin
                // illegal code: return to idle with the bus stalled
                next_st.state   = MCEL_IDLE;
                next_st.waitreq = 1'b1;
            end
        endcase
    end

    // warm reset clears the bus side only; mask survives like the flags
    always_ff @(posedge mclk) begin
        if (rst_por) begin
            cur <= '{state: MCEL_IDLE, waitreq: 1'b1, rdata: 32'h0,
                     mask: `MCEL_MASK_RST};
        end else if (rst) begin
            cur <= '{state: MCEL_IDLE, waitreq: 1'b1, rdata: 32'h0,
                     mask: cur.mask};
        end else if (ce) begin
            cur <= next_st;
        end
    end

    // outputs straight from the state flops
    assign avs_readdata    = cur.rdata;
    assign avs_waitrequest = cur.waitreq;

    // a request taken by the idle slave
    sequence s_req;
        ce && (cur.state == MCEL_IDLE) && (avs_read || avs_write);
    endsequence

    // one cycle of waitrequest low, then high again
    sequence s_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    property p_ack;
        @(posedge mclk) disable iff (rst || rst_por)
            s_req ##1 ce |-> s_ack;
    endproperty
    a_ack: assert property (p_ack)
        else $error("waitrequest not low for exactly one cycle");

    property p_chan_prio;
        @(posedge mclk) disable iff (rst || rst_por)
            (ce && (nf_first == '0) && (|nf_gated[NW-1:0])) |=> (nf_idx == 2'h0);
    endproperty
    a_chan_prio: assert property (p_chan_prio)
        else $error("channel zero did not win capture");

    property p_bit_prio;
        @(posedge mclk) disable iff (rst || rst_por)
            (ce && (fat_first == '0) && fat_gated[`MCEL_FAT_THERMAL_BIT])
            |=> (fat_first == 3'h4);
    endproperty
    a_bit_prio: assert property (p_bit_prio)
        else $error("highest fatal bit did not win");

    property p_masked;
        @(posedge mclk) disable iff (rst || rst_por)
            (ce && (fat_first == '0) && (fatal_evt != '0)
             && ((fatal_evt & ~{NCH{cur.mask[`MCEL_FAT_MASK_LSB +: FW]}}) == '0))
            |=> (fat_first == '0);
    endproperty
    a_masked: assert property (p_masked)
        else $error("masked fatal error was captured");

    property p_never_set;
        @(posedge mclk) disable iff (rst_por)
            (nf_first[22:19] == 4'h0) && (nf_next[22:19] == 4'h0)
            && !nf_first[12] && !nf_next[12];
    endproperty
    a_never_set: assert property (p_never_set)
        else $error("unused non-fatal bit was set");

    property p_idx_read;
        @(posedge mclk) disable iff (rst || rst_por)
            (ce && (cur.state == MCEL_IDLE) && avs_read && sel[0])
            |=> (avs_readdata[`MCEL_IDX_LSB +: IW] == $past(fat_idx))
                && (avs_readdata[31:30] == 2'h0);
    endproperty
    a_idx_read: assert property (p_idx_read)
        else $error("read of channel index wrong");

endmodule : mcel_top

`default_nettype wire

// *** verif/mcel_err_src.sv ***
`timescale 1ns/1ps
`default_nettype none

// stands in for the channel error detectors: one request, one cycle of event levels
module mcel_err_src (
    input  wire logic        mclk,
    input  wire logic        go,
    input  wire logic [11:0] fat_pat,
    input  wire logic [99:0] nf_pat,
    output logic [11:0]      fatal_evt,
    output logic [99:0]      nonfatal_evt
);
    // events are levels sampled each cycle, so quiet means all zero
    always_ff @(posedge mclk) begin
        fatal_evt    <= go ? fat_pat : 12'h000;
        nonfatal_evt <= go ? nf_pat : 100'h0;
    end
endmodule : mcel_err_src

`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

`include "mcel_cfg.svh"

// self-checking bench for the error logger, driven over its register bus
module tb;
    logic        mclk = 1'b0;      // 20 MHz core clock
    logic        rst = 1'b1;       // warm reset
    logic        rst_por = 1'b1;   // power-on reset
    logic        go = 1'b0;        // event request to the source model
    logic        ce = 1'b1;        // clock enable toward the block
    logic [11:0] fat_pat = 12'h000;
    logic [99:0] nf_pat = 100'h0;
    logic [11:0] fatal_evt;
    logic [99:0] nonfatal_evt;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    int          errors = 0;
    int          tests_run = 0;

    // half period of 25 ns
    always #25 mclk = ~mclk;

    mcel_err_src u_src (.mclk(mclk), .go(go), .fat_pat(fat_pat), .nf_pat(nf_pat),
        .fatal_evt(fatal_evt), .nonfatal_evt(nonfatal_evt));

    mcel_top u_dut (.mclk(mclk), .rst(rst), .rst_por(rst_por), .ce(ce),
        .fatal_evt(fatal_evt), .nonfatal_evt(nonfatal_evt), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    // counts and verdict, the only way out of the run
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // one avalon access: hold until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address   <= a;
        avs_read      <= ~wr;
        avs_write     <= wr;
        avs_writedata <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            $display("BAD bus_wait expected 0 seen %b", avs_waitrequest);
            errors++;
            close_out();
        end
    endtask : bus

    // register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    // register read and compare
    task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        tests_run++;
        if (q !== exp) begin
            $display("BAD %s expected %h seen %h", nm, exp, q);
            errors++;
        end
    endtask : chk_rd

    // one-cycle burst of events from the source model
    task automatic fire(input logic [11:0] f, input logic [99:0] n);
        @(posedge mclk);
        go      <= 1'b1;
        fat_pat <= f;
        nf_pat  <= n;
        @(posedge mclk);
        go      <= 1'b0;
    endtask : fire

    // clear every flag of all four logs
    task automatic clear_all();
        wr(`MCEL_OFS_FIRST_FAT, 32'hffffffff);
        wr(`MCEL_OFS_NEXT_FAT, 32'hffffffff);
        wr(`MCEL_OFS_FIRST_NF, 32'hffffffff);
        wr(`MCEL_OFS_NEXT_NF, 32'hffffffff);
    endtask : clear_all

    // values after power-on, unmapped place reads zero
    task automatic t_reset();
        chk_rd("mask_rst", `MCEL_OFS_MASK, 32'h0fff7fff);
        chk_rd("first_fat_rst", `MCEL_OFS_FIRST_FAT, 32'h0);
        chk_rd("next_nf_rst", `MCEL_OFS_NEXT_NF, 32'h0);
        wr(8'h00, 32'hffffffff);
        chk_rd("unmapped", 8'h00, 32'h0);
        $display("test reset done");
    endtask : t_reset

    // reserved mask bits stay zero, then every error is enabled
    task automatic t_mask_rw();
        wr(`MCEL_OFS_MASK, 32'hffffffff);
        chk_rd("mask_all", `MCEL_OFS_MASK, 32'h0fff7fff);
        wr(`MCEL_OFS_MASK, 32'h0);
        chk_rd("mask_none", `MCEL_OFS_MASK, 32'h0);
        $display("test mask done");
    endtask : t_mask_rw

    // each non-fatal bit alone, channel varies; reserved bits never set
    task automatic t_nf_bits();
        int          c;
        logic        hw;
        logic [1:0]  idx;
        logic [31:0] e;
        idx = 2'h0;
        for (int b = 0; b < 25; b++) begin
            hw = !(b == 12 || (b >= 19 && b <= 22));
            c = b % 4;
            fire(12'h000, 100'h1 << (c * 25 + b));
            if (hw) begin
                idx = c[1:0];
            end
            e = {2'h0, idx, 3'h0, (hw ? (25'h1 << b) : 25'h0)};
            chk_rd("nf_bit", `MCEL_OFS_FIRST_NF, e);
            chk_rd("next_nf_bit", `MCEL_OFS_NEXT_NF, 32'h0);
            wr(`MCEL_OFS_FIRST_NF, 32'h1 << b);
        end
        $display("test nonfatal bits done");
    endtask : t_nf_bits

    // fatal priority, next log, write-zero and write-one-clear, recapture
    task automatic t_fatal();
        fire(12'h128, 100'h0);
        chk_rd("first_fat", `MCEL_OFS_FIRST_FAT, 32'h10000004);
        chk_rd("next_fat", `MCEL_OFS_NEXT_FAT, 32'h5);
        fire(12'h002, 100'h0);
        chk_rd("first_fat_held", `MCEL_OFS_FIRST_FAT, 32'h10000004);
        chk_rd("next_fat_or", `MCEL_OFS_NEXT_FAT, 32'h7);
        wr(`MCEL_OFS_FIRST_FAT, 32'h0);
        chk_rd("first_fat_w0", `MCEL_OFS_FIRST_FAT, 32'h10000004);
        wr(`MCEL_OFS_FIRST_FAT, 32'h4);
        wr(`MCEL_OFS_NEXT_FAT, 32'h7);
        chk_rd("first_fat_clr", `MCEL_OFS_FIRST_FAT, 32'h10000000);
        chk_rd("next_fat_clr", `MCEL_OFS_NEXT_FAT, 32'h0);
        fire(12'h200, 100'h0);
        chk_rd("first_fat_again", `MCEL_OFS_FIRST_FAT, 32'h30000001);
        $display("test fatal done");
    endtask : t_fatal

    // warm reset keeps flags and mask
    task automatic t_warm();
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        chk_rd("first_fat_warm", `MCEL_OFS_FIRST_FAT, 32'h30000001);
        chk_rd("mask_warm", `MCEL_OFS_MASK, 32'h0);
        clear_all();
        $display("test warm reset done");
    endtask : t_warm

    // non-fatal competition on two channels, reserved bit ignored
    task automatic t_nf_prio();
        fire(12'h000, (100'h1 << 55) | (100'h1 << 68) | (100'h1 << 62) | (100'h1 << 99));
        chk_rd("first_nf_prio", `MCEL_OFS_FIRST_NF, 32'h20040000);
        chk_rd("next_nf_prio", `MCEL_OFS_NEXT_NF, 32'h01000020);
        clear_all();
        $display("test nonfatal priority done");
    endtask : t_nf_prio

    // masked sources never log, unmasked neighbour does
    task automatic t_masked();
        wr(`MCEL_OFS_MASK, 32'h08000001);
        fire(12'h001, (100'h1 << 24) | (100'h1 << 48));
        chk_rd("first_fat_mask", `MCEL_OFS_FIRST_FAT, 32'h30000000);
        chk_rd("next_fat_mask", `MCEL_OFS_NEXT_FAT, 32'h0);
        chk_rd("first_nf_mask", `MCEL_OFS_FIRST_NF, 32'h10800000);
        chk_rd("next_nf_mask", `MCEL_OFS_NEXT_NF, 32'h0);
        $display("test mask effect done");
    endtask : t_masked

    // enable low freezes the logs; then a channel zero thermal event wins
    task automatic t_ce();
        @(posedge mclk);
        ce <= 1'b0;
        fire(12'h004, 100'h0);
        @(posedge mclk);
        ce <= 1'b1;
        chk_rd("first_fat_frozen", `MCEL_OFS_FIRST_FAT, 32'h30000000);
        fire(12'h004, 100'h0);
        chk_rd("first_fat_thermal", `MCEL_OFS_FIRST_FAT, 32'h00000004);
        chk_rd("next_fat_thermal", `MCEL_OFS_NEXT_FAT, 32'h0);
        $display("test clock enable done");
    endtask : t_ce

    // main sequence: reset for 10 cycles, then each scenario in turn
    initial begin
        repeat (10) @(posedge mclk);
        rst     <= 1'b0;
        rst_por <= 1'b0;
        t_reset();
        t_mask_rw();
        t_nf_bits();
        t_fatal();
        t_warm();
        t_nf_prio();
        t_masked();
        t_ce();
        close_out();
    end
endmodule : tb

`default_nettype wire
